// ===== pse_status_regs.svh
// Purpose: Offsets, field positions and reset values of the channel status/mode bank
// Assumes: Byte-wide registers addressed by an 8-bit command pointer
// Notes: Definitions only
`ifndef PSE_STATUS_REGS_SVH
`define PSE_STATUS_REGS_SVH
`define REG_POWER_STATE 8'h10
`define REG_STRAP_STATUS 8'h11
`define REG_MODE_SELECT 8'h12
`define MODE_RESET 8'h00
`define POWER_RESET 8'h00
`define PG_LSB 4
`define PE_LSB 0
`define STRAP_LSB 3
`define HALF_BIT 2
`define ADDR_PREFIX 2'h1
`define BCAST_ADDR 7'h7f
`endif

// ===== pse_regs_pkg.sv
// Purpose: Types shared by the status/mode bank and its two-wire target
// Assumes: Mode codes follow enum order 0..3
// Notes: Constants live in pse_status_regs.svh
package pse_regs_pkg;
  typedef enum logic [1:0] {MODE_OFF, MODE_MANUAL, MODE_SEMI, MODE_AUTO} mode_t;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_TXACK} twi_state_t;
endpackage

// ===== reg_access_if.sv
// Purpose: Byte access path between the two-wire target and the register bank
// Assumes: One clock domain
// Notes: wrStb is a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
interface reg_access_if;
  logic [7:0] ptr;
  logic [7:0] wrData;
  logic wrStb;
  logic [7:0] rdData;
  logic [6:0] devAddr;
  modport target (output ptr, output wrData, output wrStb, input rdData, input devAddr);
  modport bank (input ptr, input wrData, input wrStb, output rdData, output devAddr);
endinterface
`default_nettype wire

// ===== twi_target.sv
// Purpose: Two-wire bus target turning bus bytes into pointer, write and read accesses
// Assumes: scl and sdaIn are asynchronous pins; host clock far below sys_clk
// Notes: First written byte sets the pointer, later ones write it; no auto-increment
`timescale 1ns/1ns
`default_nettype none
module twi_target
  import pse_regs_pkg::*;
(
  // Clock and control
  input wire logic sys_clk,
  input wire logic rstnQ,
  input wire logic ce,
  // Bus pins
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOe,
  // Register side
  reg_access_if.target bus
);
  `include "pse_status_regs.svh"

  logic [2:0] sclSync_ff, sdaSync_ff;
  logic sclF_ff, sdaF_ff, sclOld_ff, sdaOld_ff;
  logic nxt_sclF, nxt_sdaF;
  twi_state_t state_ff, nxt_state;
  logic [3:0] bitCnt_ff, nxt_bitCnt;
  logic [7:0] shift_ff, nxt_shift, ptr_ff, nxt_ptr, wrData_ff, nxt_wrData;
  logic oe_ff, nxt_oe, isRead_ff, nxt_isRead, first_ff, nxt_first, wrStb_ff, nxt_wrStb;
  logic rise, fall, start, stop;

  // Filtered levels move only when the second and third stages agree
  always_comb begin
    nxt_sclF = (sclSync_ff[1] == sclSync_ff[2]) ? sclSync_ff[2] : sclF_ff;
    nxt_sdaF = (sdaSync_ff[1] == sdaSync_ff[2]) ? sdaSync_ff[2] : sdaF_ff;
  end

  always_ff @(posedge sys_clk or negedge rstnQ) begin
    if (!rstnQ) begin
      sclSync_ff <= 3'h7;
      sdaSync_ff <= 3'h7;
      sclF_ff <= 1'b1;
      sdaF_ff <= 1'b1;
      sclOld_ff <= 1'b1;
      sdaOld_ff <= 1'b1;
    end else if (ce) begin
      sclSync_ff <= {sclSync_ff[1:0], scl};
      sdaSync_ff <= {sdaSync_ff[1:0], sdaIn};
      sclF_ff <= nxt_sclF;
      sdaF_ff <= nxt_sdaF;
      sclOld_ff <= sclF_ff;
      sdaOld_ff <= sdaF_ff;
    end
  end

  assign rise = sclF_ff & ~sclOld_ff;
  assign fall = ~sclF_ff & sclOld_ff;
  assign start = sclF_ff & sclOld_ff & sdaOld_ff & ~sdaF_ff;
  assign stop = sclF_ff & sclOld_ff & ~sdaOld_ff & sdaF_ff;

  // Byte engine; data is sampled on rise and driven after fall
  always_comb begin
    nxt_state = state_ff;
    nxt_bitCnt = bitCnt_ff;
    nxt_shift = shift_ff;
    nxt_ptr = ptr_ff;
    nxt_wrData = wrData_ff;
    nxt_oe = oe_ff;
    nxt_isRead = isRead_ff;
    nxt_first = first_ff;
    nxt_wrStb = 1'b0;
    if (start) begin
      nxt_state = ST_ADDR;
      nxt_bitCnt = 4'h0;
      nxt_oe = 1'b0;
      nxt_first = 1'b1;
    end else if (stop) begin
      nxt_state = ST_IDLE;
      nxt_oe = 1'b0;
    end else begin
      if (rise && (state_ff == ST_ADDR || state_ff == ST_RX || state_ff == ST_TX)) begin
        nxt_shift = (state_ff == ST_TX) ? shift_ff : {shift_ff[6:0], sdaF_ff};
        nxt_bitCnt = bitCnt_ff + 4'h1;
      end
      unique case (state_ff)
        ST_IDLE: ;
        ST_ADDR: if (fall && bitCnt_ff == 4'h8) begin
          // Own address, or broadcast for writes only
          if (shift_ff[7:1] == bus.devAddr
              || (shift_ff[7:1] == `BCAST_ADDR && !shift_ff[0])) begin
            nxt_state = ST_ACK;
            nxt_oe = 1'b1;
            nxt_isRead = shift_ff[0];
          end else begin
            nxt_state = ST_IDLE;
          end
        end
        ST_ACK: if (fall) begin
          nxt_bitCnt = 4'h0;
          if (isRead_ff) begin
            nxt_state = ST_TX;
            nxt_shift = bus.rdData;
            nxt_oe = ~bus.rdData[7];
          end else begin
            nxt_state = ST_RX;
            nxt_oe = 1'b0;
          end
        end
        ST_RX: if (fall && bitCnt_ff == 4'h8) begin
          nxt_state = ST_ACK;
          nxt_oe = 1'b1;
          nxt_first = 1'b0;
          if (first_ff) begin
            nxt_ptr = shift_ff;
          end else begin
            nxt_wrData = shift_ff;
            nxt_wrStb = 1'b1;
          end
        end
        ST_TX: if (fall) begin
          if (bitCnt_ff == 4'h8) begin
            nxt_state = ST_TXACK;
            nxt_oe = 1'b0;
          end else begin
            nxt_shift = {shift_ff[6:0], 1'b0};
            nxt_oe = ~shift_ff[6];
          end
        end
        ST_TXACK: if (rise) begin
          nxt_state = sdaF_ff ? ST_IDLE : ST_ACK;
        end
        default: nxt_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstnQ) begin
    if (!rstnQ) begin
      state_ff <= ST_IDLE;
      bitCnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ptr_ff <= 8'h00;
      wrData_ff <= 8'h00;
      oe_ff <= 1'b0;
      isRead_ff <= 1'b0;
      first_ff <= 1'b1;
      wrStb_ff <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      bitCnt_ff <= nxt_bitCnt;
      shift_ff <= nxt_shift;
      ptr_ff <= nxt_ptr;
      wrData_ff <= nxt_wrData;
      oe_ff <= nxt_oe;
      isRead_ff <= nxt_isRead;
      first_ff <= nxt_first;
      wrStb_ff <= nxt_wrStb;
    end
  end

  assign sdaOe = oe_ff;
  assign bus.ptr = ptr_ff;
  assign bus.wrData = wrData_ff;
  assign bus.wrStb = wrStb_ff;
endmodule // twi_target
`default_nettype wire

// ===== pse_channel_status_mode_regs.sv
// Purpose: Power status, address strap status and channel mode registers for four channels
// Assumes: Engine inputs are on sys_clk; straps and bus pins are asynchronous
// Notes: Reached over the two-wire bus through twi_target
`timescale 1ns/1ns
`default_nettype none
module pse_channel_status_mode_regs
  import pse_regs_pkg::*;
(
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  // Two-wire host bus
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Straps
  input wire logic [3:0] addressStrapPins,
  input wire logic halfSelectPin,
  input wire logic configB,
  // From power engines
  input wire logic [3:0] chanOn,
  input wire logic [3:0] turnOnDone,
  input wire logic [3:0] channelDrainSense,
  input wire logic [1:0] fourPairWired,
  input wire logic [1:0] singleSignature,
  // To power engines
  output logic [7:0] channelModeField,
  output logic [3:0] discoveryAllow,
  output logic [3:0] turnOnAllow,
  output logic [3:0] autoPowerOn,
  output logic [3:0] singleShotCycle,
  // Status
  output logic [3:0] powerGoodFlag,
  output logic [3:0] powerEnabledFlag,
  output logic [3:0] powerGoodChangeEvent,
  output logic [3:0] powerEnableChangeEvent
);
  `include "pse_status_regs.svh"

  reg_access_if bus ();

  // Mode of one channel, decoded in several places
  function automatic mode_t modeOf(input logic [7:0] m, input int ch);
    modeOf = mode_t'(m[2*ch +: 2]);
  endfunction

  logic [1:0] rstSync_ff;
  logic rstnQ;

  // Reset released through two stages so every flop on rstnQ leaves reset together
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rstSync_ff <= 2'h0;
    end else begin
      rstSync_ff <= {rstSync_ff[0], 1'b1};
    end
  end
  assign rstnQ = rstSync_ff[1];

  // Strap pins: three stages, accepted when stages two and three agree
  logic [5:0] pin1_ff, pin2_ff, pin3_ff, pinQ_ff, nxt_pinQ;
  logic [7:0] strapReg_ff, nxt_strapReg;
  logic sdaOut_ff;

  always_comb begin
    nxt_pinQ = (pin2_ff == pin3_ff) ? pin3_ff : pinQ_ff;
    nxt_strapReg = 8'h00; // Reserved bits 7, 1, 0 stay zero
    nxt_strapReg[`STRAP_LSB +: 4] = pinQ_ff[3:0];
    nxt_strapReg[`HALF_BIT] = pinQ_ff[4] & ~pinQ_ff[5];
  end

  always_ff @(posedge sys_clk or negedge rstnQ) begin
    if (!rstnQ) begin
      pin1_ff <= 6'h00;
      pin2_ff <= 6'h00;
      pin3_ff <= 6'h00;
      pinQ_ff <= 6'h00;
      strapReg_ff <= 8'h00;
      sdaOut_ff <= 1'b0;
    end else if (ce) begin
      pin1_ff <= {configB, halfSelectPin, addressStrapPins};
      pin2_ff <= pin1_ff;
      pin3_ff <= pin2_ff;
      pinQ_ff <= nxt_pinQ;
      strapReg_ff <= nxt_strapReg;
      sdaOut_ff <= 1'b0; // Open drain: only ever pulls low
    end
  end

  assign bus.devAddr = {`ADDR_PREFIX, strapReg_ff[`STRAP_LSB +: 4], strapReg_ff[`HALF_BIT]};

  // Mode register; other offsets are read-only and writes there are dropped
  logic [7:0] mode_ff, nxt_mode;
  always_comb begin
    nxt_mode = mode_ff;
    if (bus.wrStb && bus.ptr == `REG_MODE_SELECT) begin
      nxt_mode = bus.wrData;
    end
  end

  // Per-channel power tracking and engine permissions
  logic [3:0] pg_ff, nxt_pg, pe_ff, nxt_pe, pend_ff, nxt_pend;
  logic [3:0] pgEvt_ff, nxt_pgEvt, peEvt_ff, nxt_peEvt;
  logic [3:0] disc_ff, nxt_disc, ton_ff, nxt_ton, auto_ff, nxt_auto, shot_ff, nxt_shot;
  logic [3:0] pendNow, isOff;
  logic [1:0] portMatch, sig4;

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      portMatch[p] = ~fourPairWired[p] | (mode_ff[4*p +: 2] == mode_ff[4*p+2 +: 2]);
      sig4[p] = fourPairWired[p] & singleSignature[p];
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gChan
      always_comb begin
        isOff[g] = (modeOf(mode_ff, g) == MODE_OFF);
        // Drain reached the good level during this turn-on
        pendNow[g] = chanOn[g] & ~isOff[g] & (pend_ff[g] | (turnOnDone[g] & channelDrainSense[g]));
      end
    end
  endgenerate

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      nxt_pend[i] = pendNow[i];
      // Each channel follows its own state single signature waits for its partner
      nxt_pg[i] = pendNow[i] & (pg_ff[i] | ~sig4[i/2] | pendNow[i^1]);
      nxt_pe[i] = chanOn[i] & ~isOff[i];
      // Any change, including a fall to zero, raises that channel's event
      nxt_pgEvt[i] = nxt_pg[i] ^ pg_ff[i];
      nxt_peEvt[i] = nxt_pe[i] ^ pe_ff[i];
      nxt_disc[i] = ~isOff[i] & portMatch[i/2];
      nxt_ton[i] = ~isOff[i] & portMatch[i/2];
      nxt_auto[i] = (modeOf(mode_ff, i) == MODE_AUTO) & portMatch[i/2];
      nxt_shot[i] = (modeOf(mode_ff, i) == MODE_MANUAL);
    end
  end

  always_ff @(posedge sys_clk or negedge rstnQ) begin
    if (!rstnQ) begin
      mode_ff <= `MODE_RESET;
      pend_ff <= 4'h0;
      pg_ff <= 4'(`POWER_RESET >> `PG_LSB);
      pe_ff <= 4'h0;
      pgEvt_ff <= 4'h0;
      peEvt_ff <= 4'h0;
      disc_ff <= 4'h0;
      ton_ff <= 4'h0;
      auto_ff <= 4'h0;
      shot_ff <= 4'h0;
    end else if (ce) begin
      mode_ff <= nxt_mode;
      pend_ff <= nxt_pend;
      pg_ff <= nxt_pg;
      pe_ff <= nxt_pe;
      pgEvt_ff <= nxt_pgEvt;
      peEvt_ff <= nxt_peEvt;
      disc_ff <= nxt_disc;
      ton_ff <= nxt_ton;
      auto_ff <= nxt_auto;
      shot_ff <= nxt_shot;
    end
  end

  // Read mux; unmapped pointers read zero
  always_comb begin
    unique case (bus.ptr)
      `REG_POWER_STATE: bus.rdData = {pg_ff, pe_ff};
      `REG_STRAP_STATUS: bus.rdData = strapReg_ff;
      `REG_MODE_SELECT: bus.rdData = mode_ff;
      default: bus.rdData = 8'h00;
    endcase
  end

  twi_target uTarget (
    .sys_clk(sys_clk),
    .rstnQ(rstnQ),
    .ce(ce),
    .scl(scl),
    .sdaIn(sdaIn),
    .sdaOe(sdaOe),
    .bus(bus)
  );

  assign sdaOut = sdaOut_ff;
  assign channelModeField = mode_ff;
  assign discoveryAllow = disc_ff;
  assign turnOnAllow = ton_ff;
  assign autoPowerOn = auto_ff;
  assign singleShotCycle = shot_ff;
  assign powerGoodFlag = pg_ff;
  assign powerEnabledFlag = pe_ff;
  assign powerGoodChangeEvent = pgEvt_ff;
  assign powerEnableChangeEvent = peEvt_ff;

  a_pg_needs_on: assert property (@(posedge sys_clk) disable iff (!rstnQ)
    ce && !chanOn[0] |=> !pg_ff[0]) else $error("power-good set while channel off");
  a_pg_sets_done: assert property (@(posedge sys_clk) disable iff (!rstnQ)
    ce && chanOn[0] && turnOnDone[0] && channelDrainSense[0] && !sig4[0] && !isOff[0]
    |=> pg_ff[0]) else $error("power-good not latched after turn-on");
  a_pe_follows_on: assert property (@(posedge sys_clk) disable iff (!rstnQ)
    ce && chanOn[2] && !isOff[2] ##1 ce |-> pe_ff[2]) else $error("on state not shown");
  a_single_sig_pair: assert property (@(posedge sys_clk) disable iff (!rstnQ)
    sig4[1] && $rose(pg_ff[2]) |-> pg_ff[3]) else $error("single signature pair split");
  a_fall_sets_event: assert property (@(posedge sys_clk) disable iff (!rstnQ)
    $fell(pg_ff[1]) || $fell(pe_ff[1]) |-> pgEvt_ff[1] || peEvt_ff[1])
    else $error("fall without change event");
  a_mode_write_takes: assert property (@(posedge sys_clk) disable iff (!rstnQ)
    ce && bus.wrStb && bus.ptr == `REG_MODE_SELECT |=> mode_ff == $past(bus.wrData))
    else $error("mode write lost");
  a_mismatch_blocks: assert property (@(posedge sys_clk) disable iff (!rstnQ)
    ce && fourPairWired[0] && mode_ff[1:0] != mode_ff[3:2] |=> !ton_ff[0] && !disc_ff[1])
    else $error("mismatched port still allowed");
  a_off_no_disc: assert property (@(posedge sys_clk) disable iff (!rstnQ)
    ce && mode_ff[5:4] == 2'h0 |=> !disc_ff[2] && !pe_ff[2]) else $error("off channel active");
  a_config_b_half: assert property (@(posedge sys_clk) disable iff (!rstnQ)
    ce && pinQ_ff[5] |=> !strapReg_ff[`HALF_BIT]) else $error("half bit set in config B");
  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rstnQ)
    strapReg_ff[7] == 1'b0 && strapReg_ff[1:0] == 2'h0) else $error("reserved bits nonzero");
endmodule // pse_channel_status_mode_regs
`default_nettype wire

// ===== twi_host_model.sv
// Purpose: Host controller model driving the two-wire register bus
// Assumes: sda has a pull-up; the bench resolves the line level
// Notes: Phases of 10 sys_clk stay clear of the 8-cycle minimum
`timescale 1ns/1ns
`default_nettype none
module twi_host_model (
  // Clock
  input wire logic sys_clk,
  // Bus
  input wire logic sdaLine,
  output logic scl,
  output logic sdaLow
);
  // Idle bus: both lines released
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // One bus phase, edges land on the falling clock edge
  task automatic phase();
    repeat (10) @(negedge sys_clk);
  endtask
  // Data settles with scl low; a trailing low phase keeps sda clear of the scl fall
  task automatic bit_slot(input logic low, output logic seen);
    sdaLow = low;
    phase();
    scl = 1'b1;
    phase();
    seen = sdaLine;
    scl = 1'b0;
    phase();
  endtask
  // Start or repeated start
  task automatic bus_start();
    sdaLow = 1'b0;
    phase();
    scl = 1'b1;
    phase();
    sdaLow = 1'b1;
    phase();
    scl = 1'b0;
    phase();
  endtask
  task automatic bus_stop();
    sdaLow = 1'b1;
    phase();
    scl = 1'b1;
    phase();
    sdaLow = 1'b0;
    phase();
  endtask
  // MSB first; ack is high when the target pulled the ninth bit low
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(~b[i], s);
    bit_slot(1'b0, s);
    ack = ~s;
  endtask
  // Address ack returned; pointer and data acks are not needed by callers
  task automatic write_reg(input logic [6:0] addr, input logic [7:0] ptr,
                           input logic [7:0] data, output logic ack);
    logic a;
    bus_start();
    send_byte({addr, 1'b0}, ack);
    send_byte(ptr, a);
    send_byte(data, a);
    bus_stop();
  endtask
  // Pointer write, repeated start, one byte read ended by a host NACK
  task automatic read_reg(input logic [6:0] addr, input logic [7:0] ptr,
                          output logic [7:0] data, output logic ack);
    logic a;
    bus_start();
    send_byte({addr, 1'b0}, a);
    send_byte(ptr, a);
    bus_start();
    send_byte({addr, 1'b1}, ack);
    for (int i = 7; i >= 0; i--) bit_slot(1'b0, data[i]);
    bit_slot(1'b0, a);
    bus_stop();
  endtask
endmodule // twi_host_model
`default_nettype wire

// ===== pse_channel_status_mode_regs_tb_top.sv
// Purpose: Self-checking bench for the channel status and mode registers
// Assumes: Host model paces the bus; engine inputs driven on falling edges
// Notes: ce held low in one test; expectations follow the register layout
`timescale 1ns/1ns
`default_nettype none
`include "pse_status_regs.svh"
module pse_channel_status_mode_regs_tb_top;
  logic sysClk, rstn, scl, hostSdaLow, sdaOut, sdaOe, sdaLine, halfSelectPin, configB, ack;
  logic clkEn;
  logic [3:0] addressStrapPins, chanOn, turnOnDone, channelDrainSense;
  logic [3:0] discoveryAllow, turnOnAllow, autoPowerOn, singleShotCycle;
  logic [3:0] powerGoodFlag, powerEnabledFlag, powerGoodChangeEvent, powerEnableChangeEvent;
  logic [1:0] fourPairWired, singleSignature;
  logic [7:0] channelModeField, rd;
  logic [6:0] ownAddr;
  int fails, totalChecks;
  // Open-drain line with pull-up
  assign sdaLine = ~(sdaOe | hostSdaLow);
  always #25 sysClk = ~sysClk;
  pse_channel_status_mode_regs i_dut (.sys_clk(sysClk), .rstn(rstn), .ce(clkEn), .scl(scl),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .addressStrapPins(addressStrapPins),
    .halfSelectPin(halfSelectPin), .configB(configB), .chanOn(chanOn),
    .turnOnDone(turnOnDone), .channelDrainSense(channelDrainSense),
    .fourPairWired(fourPairWired), .singleSignature(singleSignature),
    .channelModeField(channelModeField), .discoveryAllow(discoveryAllow),
    .turnOnAllow(turnOnAllow), .autoPowerOn(autoPowerOn), .singleShotCycle(singleShotCycle),
    .powerGoodFlag(powerGoodFlag), .powerEnabledFlag(powerEnabledFlag),
    .powerGoodChangeEvent(powerGoodChangeEvent),
    .powerEnableChangeEvent(powerEnableChangeEvent));
  twi_host_model i_host (.sys_clk(sysClk), .sdaLine(sdaLine), .scl(scl), .sdaLow(hostSdaLow));
  task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_ack(input string what, input logic exp, input logic got);
    check_val(what, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic expect_reg(input logic [7:0] ptr, input logic [7:0] exp);
    i_host.read_reg(ownAddr, ptr, rd, ack);
    check_val($sformatf("register %h", ptr), exp, rd);
  endtask
  // Write the mode byte, read it back, then look at the engine controls
  task automatic set_mode(input logic [7:0] m, input logic [3:0] disc, auto, shot);
    i_host.write_reg(ownAddr, `REG_MODE_SELECT, m, ack);
    check_ack("mode write ack", 1'b1, ack);
    expect_reg(`REG_MODE_SELECT, m);
    check_val("mode field", m, channelModeField);
    check_val("discovery turn-on", {disc, disc}, {discoveryAllow, turnOnAllow});
    check_val("auto single-shot", {auto, shot}, {autoPowerOn, singleShotCycle});
  endtask
  // One engine cycle, then flags and one-cycle events after the next edge
  task automatic step(input logic [3:0] on, done, drain, pe, pg, peEv, pgEv);
    chanOn = on;
    turnOnDone = done;
    channelDrainSense = drain;
    @(negedge sysClk);
    turnOnDone = 4'h0;
    check_val("power flags", {pg, pe}, {powerGoodFlag, powerEnabledFlag});
    check_val("change events", {pgEv, peEv},
              {powerGoodChangeEvent, powerEnableChangeEvent});
  endtask
  task automatic test_end(input string name);
    $display("test %s done", name);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (90000) @(posedge sysClk);
    fails++;
    $display("Error watchdog expected end seen timeout");
    give_verdict();
  end
  // Main sequence
  initial begin
    sysClk = 1'b0;
    rstn = 1'b0;
    clkEn = 1'b1;
    addressStrapPins = 4'ha;
    halfSelectPin = 1'b1;
    configB = 1'b0;
    chanOn = 4'h0;
    turnOnDone = 4'h0;
    channelDrainSense = 4'h0;
    fourPairWired = 2'h0;
    singleSignature = 2'h0;
    fails = 0;
    totalChecks = 0;
    ownAddr = {`ADDR_PREFIX, 4'ha, 1'b1};
    repeat (12) @(negedge sysClk);
    rstn = 1'b1;
    repeat (20) @(negedge sysClk);
    expect_reg(`REG_MODE_SELECT, 8'h00);
    expect_reg(`REG_POWER_STATE, 8'h00);
    expect_reg(`REG_STRAP_STATUS, 8'h54);
    check_ack("sda drive value", 1'b0, sdaOut);
    test_end("reset");
    // Same mode on all four channels, each code in turn
    for (int m = 0; m < 4; m++) begin
      set_mode({4{m[1:0]}}, (m != 0) ? 4'hf : 4'h0, (m == 3) ? 4'hf : 4'h0,
               (m == 1) ? 4'hf : 4'h0);
    end
    set_mode(8'h1b, 4'h7, 4'h1, 4'h4);
    test_end("modes");
    i_host.write_reg(ownAddr ^ 7'h01, `REG_MODE_SELECT, 8'hff, ack);
    check_ack("other half ack", 1'b0, ack);
    i_host.write_reg(ownAddr ^ 7'h08, `REG_MODE_SELECT, 8'hff, ack);
    check_ack("other strap ack", 1'b0, ack);
    expect_reg(`REG_MODE_SELECT, 8'h1b);
    i_host.write_reg(`BCAST_ADDR, `REG_MODE_SELECT, 8'hff, ack);
    check_ack("broadcast write ack", 1'b1, ack);
    expect_reg(`REG_MODE_SELECT, 8'hff);
    i_host.read_reg(`BCAST_ADDR, `REG_MODE_SELECT, rd, ack);
    check_ack("broadcast read ack", 1'b0, ack);
    i_host.write_reg(ownAddr, `REG_POWER_STATE, 8'hff, ack);
    expect_reg(`REG_POWER_STATE, 8'h00);
    i_host.write_reg(ownAddr, `REG_STRAP_STATUS, 8'hff, ack);
    expect_reg(`REG_STRAP_STATUS, 8'h54);
    configB = 1'b1;
    addressStrapPins = 4'h5;
    ownAddr = {`ADDR_PREFIX, 4'h5, 1'b0};
    repeat (20) @(negedge sysClk);
    expect_reg(`REG_STRAP_STATUS, 8'h28);
    configB = 1'b0;
    addressStrapPins = 4'ha;
    ownAddr = {`ADDR_PREFIX, 4'ha, 1'b1};
    repeat (20) @(negedge sysClk);
    test_end("address");
    step(4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1);
    step(4'h1, 4'h0, 4'h0, 4'h1, 4'h1, 4'h0, 4'h0);
    expect_reg(`REG_POWER_STATE, 8'h11);
    step(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h1);
    step(4'h2, 4'h2, 4'h0, 4'h2, 4'h0, 4'h2, 4'h0);
    step(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h2, 4'h0);
    step(4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8);
    expect_reg(`REG_POWER_STATE, 8'h88);
    step(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h8, 4'h8);
    set_mode(8'hfc, 4'he, 4'he, 4'h0);
    step(4'h1, 4'h1, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0);
    step(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
    test_end("power status");
    set_mode(8'hff, 4'hf, 4'hf, 4'h0);
    fourPairWired = 2'h3;
    singleSignature = 2'h2;
    step(4'h4, 4'h4, 4'hf, 4'h4, 4'h0, 4'h4, 4'h0);
    step(4'hc, 4'h8, 4'hf, 4'hc, 4'hc, 4'h8, 4'hc);
    step(4'hd, 4'h1, 4'hf, 4'hd, 4'hd, 4'h1, 4'h1);
    step(4'hf, 4'h2, 4'hf, 4'hf, 4'hf, 4'h2, 4'h2);
    step(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'hf, 4'hf);
    test_end("four pair");
    // Manual indication follows the mode alone; the mismatch blocks the allow outputs
    set_mode(8'h07, 4'h0, 4'h0, 4'h2);
    set_mode(8'hf5, 4'hf, 4'hc, 4'h3);
    test_end("port mismatch");
    // Clock enable low: a turn-on pulse must be lost and nothing may move
    clkEn = 1'b0;
    step(4'h1, 4'h1, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0);
    check_val("frozen mode field", 8'hf5, channelModeField);
    clkEn = 1'b1;
    step(4'h1, 4'h0, 4'h1, 4'h1, 4'h0, 4'h1, 4'h0);
    step(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h0);
    test_end("clock enable");
    give_verdict();
  end
endmodule // pse_channel_status_mode_regs_tb_top
`default_nettype wire
